/* src/sap_regs.vh */
/*
 header of register offsets, field positions, reset values and timing counts
 for the serial audio input port; assumes inclusion by bare name
*/
`ifndef SAP_REGS_VH
`define SAP_REGS_VH
`define SAP_OFS_MASTER_MODE 8'h09
`define SAP_OFS_BCLK_DIV 8'h20
`define SAP_OFS_FCLK_DIV 8'h21
`define SAP_OFS_FORMAT 8'h28
`define SAP_OFS_STATUS 8'h2A
`define SAP_MM_BIT0 0
`define SAP_MM_BIT4 4
`define SAP_MM_BIT5 5
`define SAP_MM_MASTER_MASK 8'h31
`define SAP_FMT_MODE_LSB 4
`define SAP_FMT_LEN_LSB 0
`define SAP_FMT_OFFSET_BIT 2
`define SAP_FMT_I2S 2'h0
`define SAP_FMT_TDM 2'h1
`define SAP_FMT_RJ 2'h2
`define SAP_FMT_LJ 2'h3
`define SAP_LEN_16 2'h0
`define SAP_LEN_20 2'h1
`define SAP_LEN_24 2'h2
`define SAP_LEN_32 2'h3
`define SAP_RST_MASTER_MODE 8'h00
`define SAP_RST_BCLK_DIV 8'h03
`define SAP_RST_FCLK_DIV 8'h3F
`define SAP_RST_FORMAT 8'h02
`define SAP_DRIFT_MCLK 5
`define SAP_BAD_FRAMES 4
`define SAP_FIFO_DEPTH 32
`endif

/* src/sap_sync3.v */
/*
 three-flop synchroniser with agreement filter for one pin input
 assumes clk is the master clock domain
*/
`timescale 1ns/10ps
`default_nettype none
module sap_sync3
(
    input wire clk,
    input wire reset,
    input wire clkEn,
    input wire pinIn,
    output reg level
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clk)
    begin
        if (reset)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level <= 1'b0;
        end
        else if (clkEn)
        begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                level <= s3_q;
        end
    end
endmodule
`default_nettype wire

/* src/sap_fifo.v */
/*
 flip-flop fifo with valid/ready on both sides
 assumes one clock and synchronous reset
*/
`timescale 1ns/10ps
`default_nettype none
module sap_fifo
#(
    parameter WIDTH = 33,
    parameter DEPTH = 32,
    parameter AW = 5
)
(
    input wire clk,
    input wire reset,
    input wire clkEn,
    input wire flush,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_q;
    reg [AW-1:0] rd_q;
    reg [AW:0] cnt_q;
    wire push;
    wire pop;
    assign inReady = (cnt_q != DEPTH[AW:0]);
    assign outValid = (cnt_q != {(AW+1){1'b0}});
    assign outData = mem[rd_q];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    always @(posedge clk)
    begin
        if (reset || (clkEn && flush))
        begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end
        else if (clkEn)
        begin
            if (push)
            begin
                mem[wr_q] <= inData;
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop)
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule
`default_nettype wire

/* src/sap_serial_audio_port.v */
/*
 serial audio input port: slave or master bit/frame clock, i2s, lj, rj and
 tdm receive, clock supervision with forced zero, register port, sample fifo.
 assumes clk is the master clock at 40 MHz; pins arrive asynchronously
*/
`timescale 1ns/10ps
`default_nettype none
`include "sap_regs.vh"
// What this block does
// - data sampled on rising bit clock
// - frame clock is word clock or sync
// - 16/20/24/32 bit words, 32, 48 or 64 bit clocks, 128 or 256 in tdm
// - drift over five clocks forces zero
// - bad bit/frame ratio five frames forces zero
// - format register selects i2s/lj/rj/tdm
// - reset gives i2s and 24 bits
// - twos complement msb first, 32 bits max
// - slave inputs, master drives clocks out
// - master select from bits 0,4,5
// - dividers from two divider registers
// - i2s low is left, high right
// - tdm only under software control
// - tdm frame starts at sync rise
// - tdm offset zero or one
module sap_serial_audio_port
#(
    parameter DEPTH = `SAP_FIFO_DEPTH,
    parameter DRIFT = `SAP_DRIFT_MCLK,
    parameter BAD_FRAMES = `SAP_BAD_FRAMES
)
(
    input wire clk,
    input wire reset,
    input wire clkEn,
    input wire softwareMode,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire bitClockIn,
    output reg bitClockOut,
    output reg bitClockOe,
    input wire frameClockIn,
    output reg frameClockOut,
    output reg frameClockOe,
    input wire serialDataIn,
    output reg sampleValid,
    input wire sampleReady,
    output reg [31:0] sampleData,
    output reg sampleRight,
    output reg zeroForced
);
    reg [7:0] masterMode_q;
    reg [7:0] bclkDiv_q;
    reg [7:0] fclkDiv_q;
    reg [7:0] format_q;
    wire bclkS;
    wire fclkS;
    wire dataS;
    reg bclkPrev_q;
    reg fclkPrev_q;
    reg [7:0] bdivCnt_q;
    reg [7:0] fdivCnt_q;
    reg [5:0] bitCnt_q;
    reg [8:0] frameBits_q;
    reg [8:0] lastFrameBits_q;
    reg [15:0] mclkPerFrame_q;
    reg [15:0] lastMclk_q;
    reg [2:0] badCnt_q;
    reg haveRef_q;
    reg lockErr_q;
    reg [31:0] shift_q;
    reg [5:0] got_q;
    reg [1:0] slot_q;
    reg capture;
    reg fifoIn;
    wire fifoReady;
    wire fifoOutValid;
    wire [32:0] fifoOut;
    wire isMaster;
    wire [1:0] fmt;
    wire [5:0] wordLen;
    wire bRise;
    wire fRise;
    wire fEdge;
    wire frameStart;
    wire bclkLive;
    wire fclkLive;
    wire [15:0] drift;

    // word length decode used by rj alignment and capture
    function [5:0] lenBits;
        input [1:0] code;
        begin
            case (code)
                `SAP_LEN_16: lenBits = 6'h10;
                `SAP_LEN_20: lenBits = 6'h14;
                `SAP_LEN_24: lenBits = 6'h18;
                default: lenBits = 6'h20;
            endcase
        end
    endfunction

    // absolute difference of two frame lengths
    function [15:0] absDiff;
        input [15:0] a;
        input [15:0] b;
        begin
            absDiff = (a > b) ? a - b : b - a;
        end
    endfunction

    assign isMaster = masterMode_q[`SAP_MM_BIT0] && masterMode_q[`SAP_MM_BIT4]
        && masterMode_q[`SAP_MM_BIT5];
    // tdm falls back to i2s in pin-configured mode
    assign fmt = (format_q[5:4] == `SAP_FMT_TDM && !softwareMode) ? `SAP_FMT_I2S
        : format_q[5:4];
    assign wordLen = lenBits(format_q[1:0]);
    assign bclkLive = isMaster ? bitClockOut : bclkS;
    assign fclkLive = isMaster ? frameClockOut : fclkS;
    assign bRise = bclkLive && !bclkPrev_q;
    assign fRise = fclkLive && !fclkPrev_q;
    assign fEdge = fclkLive != fclkPrev_q;
    assign frameStart = (fmt == `SAP_FMT_TDM) ? fRise : fEdge;
    assign drift = absDiff(mclkPerFrame_q, lastMclk_q);

    sap_sync3 uSyncB (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(bitClockIn),
        .level(bclkS)
    );
    sap_sync3 uSyncF (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(frameClockIn),
        .level(fclkS)
    );
    sap_sync3 uSyncD (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .pinIn(serialDataIn),
        .level(dataS)
    );

    // register port
    always @(posedge clk)
    begin
        if (reset)
        begin
            masterMode_q <= `SAP_RST_MASTER_MODE;
            bclkDiv_q <= `SAP_RST_BCLK_DIV;
            fclkDiv_q <= `SAP_RST_FCLK_DIV;
            format_q <= `SAP_RST_FORMAT;
            regRdata <= 8'h00;
        end
        else if (clkEn)
        begin
            if (regWrite)
            begin
                case (regAddr)
                    `SAP_OFS_MASTER_MODE: masterMode_q <= regWdata;
                    `SAP_OFS_BCLK_DIV: bclkDiv_q <= {1'b0, regWdata[6:0]};
                    `SAP_OFS_FCLK_DIV: fclkDiv_q <= regWdata;
                    `SAP_OFS_FORMAT: format_q <= regWdata;
                    default: ;
                endcase
            end
            if (regRead)
            begin
                case (regAddr)
                    `SAP_OFS_MASTER_MODE: regRdata <= masterMode_q;
                    `SAP_OFS_BCLK_DIV: regRdata <= bclkDiv_q;
                    `SAP_OFS_FCLK_DIV: regRdata <= fclkDiv_q;
                    `SAP_OFS_FORMAT: regRdata <= format_q;
                    `SAP_OFS_STATUS: regRdata <= {5'h00, fifoOutValid, isMaster, lockErr_q};
                    default: regRdata <= 8'h00;
                endcase
            end
        end
    end

    // master clock dividers
    always @(posedge clk)
    begin
        if (reset)
        begin
            bdivCnt_q <= 8'h00;
            fdivCnt_q <= 8'h00;
            bitClockOut <= 1'b0;
            frameClockOut <= 1'b0;
            bitClockOe <= 1'b0;
            frameClockOe <= 1'b0;
        end
        else if (clkEn)
        begin
            bitClockOe <= isMaster;
            frameClockOe <= isMaster;
            if (!isMaster)
            begin
                bdivCnt_q <= 8'h00;
                fdivCnt_q <= 8'h00;
                bitClockOut <= 1'b0;
                frameClockOut <= 1'b0;
            end
            else if (bdivCnt_q >= bclkDiv_q)
            begin
                bdivCnt_q <= 8'h00;
                bitClockOut <= !bitClockOut;
                if (bitClockOut)
                begin
                    if (fdivCnt_q >= fclkDiv_q)
                    begin
                        fdivCnt_q <= 8'h00;
                        frameClockOut <= !frameClockOut;
                    end
                    else
                        fdivCnt_q <= fdivCnt_q + 8'h01;
                end
            end
            else
                bdivCnt_q <= bdivCnt_q + 8'h01;
        end
    end

    // frame supervision
    always @(posedge clk)
    begin
        if (reset)
        begin
            bclkPrev_q <= 1'b0;
            fclkPrev_q <= 1'b0;
            frameBits_q <= 9'h000;
            lastFrameBits_q <= 9'h000;
            mclkPerFrame_q <= 16'h0000;
            lastMclk_q <= 16'h0000;
            badCnt_q <= 3'h0;
            haveRef_q <= 1'b0;
            lockErr_q <= 1'b1;
            zeroForced <= 1'b1;
        end
        else if (clkEn)
        begin
            bclkPrev_q <= bclkLive;
            fclkPrev_q <= fclkLive;
            zeroForced <= lockErr_q;
            if (bRise)
                frameBits_q <= frameBits_q + 9'h001;
            if (mclkPerFrame_q != 16'hFFFF)
                mclkPerFrame_q <= mclkPerFrame_q + 16'h0001;
            if (fRise)
            begin
                frameBits_q <= 9'h000;
                mclkPerFrame_q <= 16'h0000;
                lastMclk_q <= mclkPerFrame_q;
                lastFrameBits_q <= frameBits_q;
                haveRef_q <= 1'b1;
                // bit count per frame must be one of the legal ratios
                if ((fmt == `SAP_FMT_TDM) ? (frameBits_q != 9'h080 && frameBits_q != 9'h100)
                    : (frameBits_q != 9'h020 && frameBits_q != 9'h030
                    && frameBits_q != 9'h040))
                begin
                    if (badCnt_q != BAD_FRAMES[2:0])
                        badCnt_q <= badCnt_q + 3'h1;
                    else
                        lockErr_q <= 1'b1;
                end
                else
                    badCnt_q <= 3'h0;
                if (haveRef_q && drift > DRIFT[15:0])
                    lockErr_q <= 1'b1;
                else if (haveRef_q && badCnt_q == 3'h0
                    && frameBits_q == lastFrameBits_q)
                    lockErr_q <= 1'b0;
            end
        end
    end

    // receive shifter
    always @*
    begin
        capture = 1'b0;
        if (bRise && !frameStart)
        begin
            case (fmt)
                `SAP_FMT_RJ: capture = 1'b1;
                default: capture = (got_q < wordLen);
            endcase
        end
    end

    always @(posedge clk)
    begin
        if (reset)
        begin
            shift_q <= 32'h00000000;
            got_q <= 6'h00;
            bitCnt_q <= 6'h00;
            slot_q <= 2'h0;
            fifoIn <= 1'b0;
            sampleValid <= 1'b0;
            sampleData <= 32'h00000000;
            sampleRight <= 1'b0;
        end
        else if (clkEn)
        begin
            fifoIn <= 1'b0;
            if (lockErr_q)
            begin
                got_q <= 6'h00;
                bitCnt_q <= 6'h00;
            end
            else if (frameStart || (bRise && bitCnt_q == 6'h3F))
            begin
                bitCnt_q <= 6'h00;
                got_q <= 6'h00;
                shift_q <= (fmt == `SAP_FMT_RJ) ? shift_q : 32'h00000000;
                slot_q <= (fmt == `SAP_FMT_TDM && !frameStart) ? slot_q + 2'h1 : 2'h0;
            end
            else if (bRise)
            begin
                bitCnt_q <= bitCnt_q + 6'h01;
                // i2s and tdm offset one skip the first bit clock
                if (!((fmt == `SAP_FMT_I2S || (fmt == `SAP_FMT_TDM
                    && format_q[`SAP_FMT_OFFSET_BIT])) && bitCnt_q == 6'h00))
                begin
                    if (fmt == `SAP_FMT_RJ)
                        shift_q <= {shift_q[30:0], dataS};
                    else if (capture)
                    begin
                        shift_q <= {shift_q[30:0], dataS};
                        got_q <= got_q + 6'h01;
                        if (got_q + 6'h01 == wordLen)
                            fifoIn <= 1'b1;
                    end
                end
            end
            // rj sample is complete at the frame clock edge ending the half
            if (fmt == `SAP_FMT_RJ && fEdge && !lockErr_q)
                fifoIn <= 1'b1;
            if (fifoOutValid && (!sampleValid || sampleReady))
            begin
                sampleValid <= 1'b1;
                sampleData <= fifoOut[31:0];
                sampleRight <= fifoOut[32];
            end
            else if (sampleReady)
                sampleValid <= 1'b0;
        end
    end

    // left-align the word, sign is the msb; zero while errored
    wire [31:0] aligned;
    wire rightSide;
    assign aligned = lockErr_q ? 32'h00000000 : (shift_q << (6'h20 - wordLen));
    assign rightSide = (fmt == `SAP_FMT_TDM) ? slot_q[0]
        : (fmt == `SAP_FMT_LJ) ? !fclkPrev_q : fclkPrev_q;

    sap_fifo #(.WIDTH(33), .DEPTH(DEPTH), .AW(5)) uFifo (
        .clk(clk),
        .reset(reset),
        .clkEn(clkEn),
        .flush(lockErr_q),
        .inValid(fifoIn),
        .inReady(fifoReady),
        .inData({rightSide, aligned}),
        .outValid(fifoOutValid),
        .outReady(!sampleValid || sampleReady),
        .outData(fifoOut)
    );
endmodule
`default_nettype wire

/* testbench/sap_props.sv */
/* checker for sap_serial_audio_port ports
 assumes bind from tb_top, one clock domain */
`timescale 1ns/10ps
`default_nettype none
module sap_props
(
    input wire clk,
    input wire reset,
    input wire clkEn,
    input wire regWrite,
    input wire regRead,
    input wire [7:0] regAddr,
    input wire [7:0] regWdata,
    input wire [7:0] regRdata,
    input wire bitClockOut,
    input wire bitClockOe,
    input wire frameClockOe,
    input wire sampleValid,
    input wire sampleReady,
    input wire [31:0] sampleData,
    input wire zeroForced
);
    logic [9:0] ageQ;
    logic [7:0] runQ;
    logic [7:0] bdivQ;
    logic lastQ;
    wire cfgWr = regWrite && clkEn && (regAddr == 8'h09 || regAddr[7:1] == 7'h10);
    wire mmWr = regWrite && clkEn && regAddr == 8'h09;
    wire mmOn = regWdata[5:4] == 2'h3 && regWdata[0];
    // settle age after clock setup and run length of bit clock
    always @(posedge clk)
    begin
        if (reset || cfgWr)
            ageQ <= 10'h000;
        else if (ageQ != 10'h3FF)
            ageQ <= ageQ + 10'h001;
        if (reset)
            bdivQ <= 8'h03;
        else if (regWrite && clkEn && regAddr == 8'h20)
            bdivQ <= regWdata;
        runQ <= (bitClockOut != lastQ) ? 8'h01 : runQ + 8'h01;
        lastQ <= bitClockOut;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    property p_oe_pair;
        bitClockOe == frameClockOe;
    endproperty
    a_oe_pair: assert property (p_oe_pair) else $error("oe pair differs");
    property p_master_on;
        mmWr && mmOn |-> ##[1:4] bitClockOe;
    endproperty
    a_master_on: assert property (p_master_on) else $error("master not on");
    property p_master_off;
        mmWr && !mmOn |-> ##[1:4] !bitClockOe;
    endproperty
    a_master_off: assert property (p_master_off) else $error("master not off");
    property p_bdiv_top;
        regRead && clkEn && regAddr == 8'h20 |=> regRdata[7] == 1'b0;
    endproperty
    a_bdiv_top: assert property (p_bdiv_top) else $error("divider bit7 set");
    property p_unmapped;
        regRead && clkEn && !(regAddr inside {8'h09, 8'h20, 8'h21, 8'h28, 8'h2A})
            |=> regRdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_rd_stand;
        !(regRead && clkEn) |=> $stable(regRdata);
    endproperty
    a_rd_stand: assert property (p_rd_stand) else $error("read data moved");
    property p_flush;
        $rose(zeroForced) |-> ##[0:2] !sampleValid;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush on error");
    property p_hold;
        sampleValid && !sampleReady && !zeroForced
            |=> zeroForced || (sampleValid && $stable(sampleData));
    endproperty
    a_hold: assert property (p_hold) else $error("sample not held");
    property p_bclk_half;
        ageQ == 10'h3FF && bitClockOe && bitClockOut != lastQ
            |-> runQ == {1'b0, bdivQ[6:0]} + 8'h01;
    endproperty
    a_bclk_half: assert property (p_bclk_half) else $error("bit clock half wrong");
    c_master: cover property (bitClockOe);
    c_lock: cover property ($fell(zeroForced));
    c_stall: cover property (sampleValid && !sampleReady ##1 sampleReady);
endmodule
`default_nettype wire

/* testbench/sap_audio_source.sv */
/* host audio source: bit clock, frame clock, serial data
 assumes mode 0 i2s 1 lj 2 rj 3 tdm 4 tdm offset one */
`timescale 1ns/10ps
`default_nettype none
module sap_audio_source
(
    input wire logic clk,
    input wire logic run,
    input wire logic [2:0] mode,
    input wire logic [5:0] wordLen,
    input wire logic [4:0] half,
    input wire logic [7:0] frameBits,
    input wire logic [31:0] leftWord,
    input wire logic [31:0] rightWord,
    output logic bitClock = 1'b0,
    output logic frameClock = 1'b0,
    output logic serialData = 1'b0
);
    logic [5:0] phaseQ = 6'h00;
    logic [7:0] bitQ = 8'h00;
    logic [4:0] halfQ = 5'h04;
    logic [7:0] bitsQ = 8'h40;
    int ch;
    int d;
    int idx;
    always @(posedge clk)
    begin
        if (!run)
        begin
            bitClock <= 1'b0;
            phaseQ <= 6'h00;
            bitQ <= 8'h00;
            halfQ <= half;
            bitsQ <= frameBits;
            serialData <= ~serialData;
        end
        else
        begin
            phaseQ <= (phaseQ == {halfQ, 1'b0} - 6'h01) ? 6'h00 : phaseQ + 6'h01;
            if (phaseQ == {1'b0, halfQ})
                bitClock <= 1'b1;
            // new rate only at a frame boundary, so the frame length holds
            if (bitQ == 8'h00 && phaseQ == {halfQ, 1'b0} - 6'h01)
            begin
                halfQ <= half;
                bitsQ <= frameBits;
            end
            if (phaseQ == 6'h00)
            begin
                bitClock <= 1'b0;
                ch = (mode >= 3) ? int'(bitQ[6]) : int'(bitQ >= bitsQ / 2);
                d = (mode == 0) ? 1 : (mode == 2) ? int'(bitsQ) / 2 - int'(wordLen) : 0;
                idx = int'(bitQ) - ch * int'(bitsQ) / 2 - d;
                if (mode >= 3)
                    idx = int'(bitQ[5:0]) - int'(mode) + 3;
                // sync high one bit at frame start, i2s left low
                frameClock <= (mode >= 3) ? (bitQ == 8'h00) : ((mode == 0) ? ch[0] : !ch[0]);
                if (idx >= 0 && idx < int'(wordLen))
                    serialData <= ch[0] ? rightWord[31 - idx] : leftWord[31 - idx];
                else
                    serialData <= ~serialData;
                bitQ <= (bitQ + 8'h01 == bitsQ) ? 8'h00 : bitQ + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
/* self-checking bench for sap_serial_audio_port
 assumes the audio source model and the checker file */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic softwareMode = 1'b1;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic sampleReady = 1'b1;
    logic run = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [5:0] wordLen = 6'h18;
    logic [4:0] half = 5'h04;
    logic [7:0] frameBits = 8'h40;
    logic [31:0] leftWord = 32'hC35A96E1;
    logic [31:0] rightWord = 32'h5A3C0F87;
    logic [7:0] fmtTab [6] = '{8'h02, 8'h33, 8'h20, 8'h11, 8'h17, 8'h12};
    logic [2:0] modeTab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [5:0] lenTab [6] = '{6'h18, 6'h20, 6'h10, 6'h14, 6'h20, 6'h18};
    wire [7:0] regRdata;
    wire bitClockOut, bitClockOe, frameClockOut, frameClockOe, srcBit, srcFrame, srcData;
    wire sampleValid, sampleRight, zeroForced;
    wire [31:0] sampleData;
    wire bitLine = bitClockOe ? bitClockOut : srcBit;
    wire frameLine = frameClockOe ? frameClockOut : srcFrame;
    int errors = 0;
    int compares = 0;
    int n;
    int cnt;
    logic r;
    logic pr;
    always #12.5 clk = ~clk;
    sap_serial_audio_port i_dut (.clk(clk), .reset(reset), .clkEn(1'b1),
        .softwareMode(softwareMode), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .bitClockIn(bitLine), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
        .frameClockIn(frameLine), .frameClockOut(frameClockOut), .frameClockOe(frameClockOe),
        .serialDataIn(srcData), .sampleValid(sampleValid), .sampleReady(sampleReady),
        .sampleData(sampleData), .sampleRight(sampleRight), .zeroForced(zeroForced));
    sap_audio_source i_src (.clk(clk), .run(run), .mode(mode), .wordLen(wordLen),
        .half(half), .frameBits(frameBits), .leftWord(leftWord), .rightWord(rightWord),
        .bitClock(srcBit), .frameClock(srcFrame), .serialData(srcData));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic regWr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic regRd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1 check({24'h0, regRdata & m}, {24'h0, e & m});
    endtask
    task automatic waitZero(input logic lvl, input int lim);
        n = 0;
        while (zeroForced !== lvl && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        check({31'h0, zeroForced}, {31'h0, lvl});
    endtask
    // take one word, check data left aligned and channel alternation
    task automatic getWord(input logic alt);
        n = 0;
        pr = r;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(sampleValid === 1'b1 && sampleReady) && n < 3000);
        r = sampleRight;
        check(sampleData, (r ? rightWord : leftWord) & ~(32'hFFFFFFFF >> wordLen));
        if (alt)
            check({31'h0, r}, {31'h0, !pr});
    endtask
    task automatic span(input logic sel, input int exp);
        logic v;
        v = sel ? frameClockOut : bitClockOut;
        for (int j = 0; j < 2; j++)
        begin
            n = 1;
            @(posedge clk);
            while ((sel ? frameClockOut : bitClockOut) === v && n < 500)
            begin
                @(posedge clk);
                n++;
            end
            v = ~v;
        end
        check(n, exp);
    endtask
    initial
    begin
        #2000000;
        errors++;
        give_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        regRd(8'h09, 8'h00, 8'hFF);
        regRd(8'h20, 8'h03, 8'hFF);
        regRd(8'h21, 8'h3F, 8'hFF);
        regRd(8'h28, 8'h02, 8'hFF);
        regRd(8'h55, 8'h00, 8'hFF);
        regWr(8'h20, 8'hFF);
        regRd(8'h20, 8'h7F, 8'hFF);
        regWr(8'h20, 8'h03);
        regWr(8'h2A, 8'hFF);
        regRd(8'h2A, 8'h00, 8'h02);
        for (int i = 0; i < 6; i++)
        begin
            run <= 1'b0;
            softwareMode <= (i != 5);
            regWr(8'h28, fmtTab[i]);
            mode <= modeTab[i];
            wordLen <= lenTab[i];
            frameBits <= (modeTab[i] >= 3) ? 8'h80 : 8'h40;
            @(posedge clk);
            run <= 1'b1;
            repeat (1500) @(posedge clk);
            waitZero(1'b0, 6000);
            repeat (2100) @(posedge clk);
            getWord(1'b0);
            for (int k = 0; k < 3; k++) getWord(1'b1);
        end
        sampleReady <= 1'b0;
        repeat (12000) @(posedge clk);
        check({31'h0, sampleValid}, 32'h1);
        sampleReady <= 1'b1;
        cnt = 0;
        repeat (40)
        begin
            @(posedge clk);
            if (sampleValid === 1'b1 && sampleReady)
                cnt++;
        end
        check(32'(cnt >= 32 && cnt <= 34), 32'h1);
        half <= 5'h05;
        waitZero(1'b1, 1400);
        waitZero(1'b0, 6000);
        repeat (1400) @(posedge clk);
        getWord(1'b0);
        half <= 5'h14;
        frameBits <= 8'h10;
        repeat (1900) @(posedge clk);
        check({31'h0, zeroForced}, 32'h0);
        waitZero(1'b1, 3300);
        half <= 5'h05;
        frameBits <= 8'h40;
        waitZero(1'b0, 6000);
        run <= 1'b0;
        regWr(8'h09, 8'h01);
        repeat (3) @(posedge clk);
        check({31'h0, bitClockOe}, 32'h0);
        regWr(8'h20, 8'h02);
        regWr(8'h21, 8'h03);
        regWr(8'h09, 8'h31);
        repeat (3) @(posedge clk);
        check({30'h0, bitClockOe, frameClockOe}, 32'h3);
        regRd(8'h2A, 8'h02, 8'h02);
        span(1'b0, 3);
        span(1'b1, 24);
        repeat (1100) @(posedge clk);
        regWr(8'h09, 8'h00);
        repeat (3) @(posedge clk);
        check({31'h0, frameClockOe}, 32'h0);
        give_verdict();
    end
endmodule
bind sap_serial_audio_port sap_props i_props (.clk(clk), .reset(reset), .clkEn(clkEn),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .bitClockOut(bitClockOut), .bitClockOe(bitClockOe),
    .frameClockOe(frameClockOe), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .sampleData(sampleData), .zeroForced(zeroForced));
`default_nettype wire
